// ===== src/shift_pkg.sv
// Package of constants, types and register map for the shift unit.
// How it works
// - Register-count right shift, one cycle per position.
// - Immediate right shift, cycles equal literal count.
// - Immediate signed left shift, one cycle each.
// - Signed shifts keep the sign bit unchanged.
// - Byte right shift moves eight in one cycle.
// - Register-count signed right shift preserves sign bit.
// - Literal count is a four-bit field.
// - Right shifts flag discarded nonzero bits.
// - Immediate signed shifts update the overflow flag.
// - Operands come only from the working-register set.
// - Register-count left shift, cycles equal the low four bits of count.
package shift_pkg;

  localparam int DATA_W   = 16;
  localparam int REG_NUM  = 8;
  localparam int REG_AW   = 3;
  localparam int IMM_W    = 4;
  localparam int BYTE_SH  = 8;

  // Instruction opcodes, upper bits of the instruction word.
  localparam logic [9:0] OPC_SHL   = 10'h0ba; // 0010111010 -> bits 15:6
  localparam logic [9:0] OPC_SHLS  = 10'h0b8;
  localparam logic [9:0] OPC_SHR   = 10'h0b9;
  localparam logic [9:0] OPC_SHRS  = 10'h0b7;
  localparam logic [8:0] OPC_SHLI  = 9'h05a;  // bits 15:7
  localparam logic [8:0] OPC_SHLSI = 9'h058;
  localparam logic [8:0] OPC_SHRI  = 9'h059;
  localparam logic [8:0] OPC_SHRSI = 9'h04f;
  localparam logic [12:0] OPC_BYTE_RIGHT_SHIFT = 13'h05de; // bits 15:3

  // Instruction field positions.
  localparam int DST_LSB = 0;
  localparam int CNT_LSB = 3;
  localparam int IMM_LSB = 3;

  // APB register map (byte addresses).
  localparam logic [7:0] ADDR_INSTR  = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MK = 8'h0c;
  localparam logic [7:0] ADDR_REG0   = 8'h20;

  // Status and interrupt bit positions.
  localparam int ST_BUSY = 0;
  localparam int ST_SB   = 1;
  localparam int ST_OV   = 2;
  localparam int ST_PL   = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OV   = 1;
  localparam int IRQ_PL   = 2;
  localparam int IRQ_REFUSED = 3;
  localparam int IRQ_W    = 4;

  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

  typedef enum logic [2:0] {
    SH_LEFT, SH_LEFT_S, SH_RIGHT, SH_RIGHT_S, SH_BYTE
  } shift_mode_type;

  typedef struct packed {
    logic           valid;
    shift_mode_type mode;
    logic [2:0]     dst;
    logic [2:0]     cnt_reg;
    logic [3:0]     imm;
    logic           use_imm;
  } decoded_type;

  typedef struct packed {
    logic shifted_out;
    logic overflow;
    logic precision_loss;
  } flags_type;

endpackage

// ===== src/shift_step.sv
`timescale 1ns/100ps
// One-position (or byte) shift step with its condition flags.
module shift_step (
  input  wire logic [15:0]                value_in,  // Operand before step.
  input  wire shift_pkg::shift_mode_type  mode,      // Shift variant.
  output logic      [15:0]                value_out, // Operand after step.
  output shift_pkg::flags_type            flags      // Flags raised by this step.
);

  // Compute one step; signed variants hold bit 15 in place.
  always_comb begin
    value_out = value_in;
    flags     = '0;
    case (mode)
      shift_pkg::SH_LEFT: begin
        value_out         = {value_in[14:0], 1'b0};
        flags.shifted_out = value_in[15];
        flags.overflow    = value_in[15];
      end
      shift_pkg::SH_LEFT_S: begin
        value_out         = {value_in[15], value_in[13:0], 1'b0};
        flags.shifted_out = value_in[14];
        // Overflow when the bit leaving differs from the held sign.
        flags.overflow    = value_in[14] ^ value_in[15];
      end
      shift_pkg::SH_RIGHT: begin
        value_out            = {1'b0, value_in[15:1]};
        flags.shifted_out    = value_in[0];
        flags.precision_loss = value_in[0];
      end
      shift_pkg::SH_RIGHT_S: begin
        value_out            = {value_in[15], value_in[15:1]};
        flags.shifted_out    = value_in[0];
        flags.precision_loss = value_in[0];
        flags.overflow       = value_in[0];
      end
      shift_pkg::SH_BYTE: begin
        value_out            = {8'h00, value_in[15:8]};
        flags.shifted_out    = value_in[7];
        flags.precision_loss = |value_in[7:0];
      end
      default: begin
        value_out = value_in;
      end
    endcase
  end

endmodule

// ===== src/shift_unit.sv
`timescale 1ns/100ps
// Shift section of the microcore arithmetic unit with APB register access.
module shift_unit (
  input  wire logic        pclk,    // Core clock, 25 MHz.
  input  wire logic        presetn, // Asynchronous reset, active low.
  input  wire logic        psel,    // APB select.
  input  wire logic        penable, // APB enable.
  input  wire logic        pwrite,  // APB write.
  input  wire logic [7:0]  paddr,   // APB byte address.
  input  wire logic [31:0] pwdata,  // APB write data.
  output logic      [31:0] prdata,  // APB read data.
  output logic             pready,  // APB ready.
  output logic             pslverr, // APB error on unmapped address.
  output logic             busy,    // Shift in progress, single-cycle byte shifts included.
  output logic             irq      // Level interrupt.
);

  typedef enum logic [1:0] {IDLE, RUN, BYTE_DONE} state_type;

  logic [15:0]                arith_operand_set_q [shift_pkg::REG_NUM];
  state_type                  state_q;
  shift_pkg::decoded_type     op_q;
  logic [15:0]                work_q;
  logic [3:0]                 remain_q;
  shift_pkg::flags_type       flags_q;
  shift_pkg::flags_type       acc_d;
  logic [15:0]                step_out;
  shift_pkg::flags_type       step_flags;
  logic [shift_pkg::IRQ_W-1:0] irq_st_q;
  logic [shift_pkg::IRQ_W-1:0] irq_mk_q;
  logic [shift_pkg::IRQ_W-1:0] irq_set;
  shift_pkg::decoded_type     dec;
  logic                       wr_en;
  logic                       rd_en;
  logic                       issue;
  logic                       done_pulse;
  logic [15:0]                count_val;
  logic                       reg_hit;
  logic [2:0]                 reg_idx;

  // Decode a 16-bit instruction word into a shift operation.
  function automatic shift_pkg::decoded_type decode(input logic [15:0] ins);
    shift_pkg::decoded_type d;
    d = '0;
    d.dst = ins[shift_pkg::DST_LSB +: 3];
    d.cnt_reg = ins[shift_pkg::CNT_LSB +: 3];
    d.imm = ins[shift_pkg::IMM_LSB +: shift_pkg::IMM_W];
    if (ins[15:3] == shift_pkg::OPC_BYTE_RIGHT_SHIFT) begin
      d.valid = 1'b1;
      d.mode  = shift_pkg::SH_BYTE;
    end else if (ins[15:6] == shift_pkg::OPC_SHL) begin
      d.valid = 1'b1;
      d.mode  = shift_pkg::SH_LEFT;
    end else if (ins[15:6] == shift_pkg::OPC_SHLS) begin
      d.valid = 1'b1;
      d.mode  = shift_pkg::SH_LEFT_S;
    end else if (ins[15:6] == shift_pkg::OPC_SHR) begin
      d.valid = 1'b1;
      d.mode  = shift_pkg::SH_RIGHT;
    end else if (ins[15:6] == shift_pkg::OPC_SHRS) begin
      d.valid = 1'b1;
      d.mode  = shift_pkg::SH_RIGHT_S;
    end else if (ins[15:7] == shift_pkg::OPC_SHLI) begin
      d.valid   = 1'b1;
      d.use_imm = 1'b1;
      d.mode    = shift_pkg::SH_LEFT;
    end else if (ins[15:7] == shift_pkg::OPC_SHLSI) begin
      d.valid   = 1'b1;
      d.use_imm = 1'b1;
      d.mode    = shift_pkg::SH_LEFT_S;
    end else if (ins[15:7] == shift_pkg::OPC_SHRI) begin
      d.valid   = 1'b1;
      d.use_imm = 1'b1;
      d.mode    = shift_pkg::SH_RIGHT;
    end else if (ins[15:7] == shift_pkg::OPC_SHRSI) begin
      d.valid   = 1'b1;
      d.use_imm = 1'b1;
      d.mode    = shift_pkg::SH_RIGHT_S;
    end
    return d;
  endfunction

  // APB decode; every access completes with no wait state.
  assign pready   = 1'b1;
  assign wr_en    = psel & penable & pwrite;
  assign rd_en    = psel & penable & ~pwrite;
  assign reg_hit  = (paddr[7:5] == shift_pkg::ADDR_REG0[7:5]) && (paddr[1:0] == 2'b00);
  assign reg_idx  = paddr[4:2];
  assign dec      = decode(pwdata[15:0]);

  // Instructions arriving while busy are refused, as the unit would ignore them.
  assign issue     = wr_en && (paddr == shift_pkg::ADDR_INSTR) && dec.valid && (state_q == IDLE);
  assign count_val = dec.use_imm ? {12'h000, dec.imm} : arith_operand_set_q[dec.cnt_reg];

  shift_step u_step (
    .value_in  (work_q),
    .mode      (op_q.mode),
    .value_out (step_out),
    .flags     (step_flags)
  );

  // Overflow and precision-loss flags accumulate over the steps of one shift; shifted-out keeps the last step.
  assign acc_d.shifted_out    = step_flags.shifted_out;
  assign acc_d.overflow       = flags_q.overflow | step_flags.overflow;
  assign acc_d.precision_loss = flags_q.precision_loss | step_flags.precision_loss;

  // Shift sequencer: one position per clock, byte shift in one clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= IDLE;
      op_q     <= '0;
      work_q   <= shift_pkg::REG_RESET;
      remain_q <= 4'h0;
      flags_q  <= '0;
    end else begin
      case (state_q)
        IDLE: begin
          if (issue) begin
            op_q    <= dec;
            work_q  <= arith_operand_set_q[dec.dst];
            flags_q <= '0;
            if (dec.mode == shift_pkg::SH_BYTE) begin
              remain_q <= 4'h1;
              state_q  <= BYTE_DONE;
            end else if (count_val[3:0] != 4'h0) begin
              // Counts above fifteen wrap to the low four bits, as the operand is 16 wide.
              remain_q <= count_val[3:0];
              state_q  <= RUN;
            end
          end
        end
        RUN: begin
          work_q   <= step_out;
          flags_q  <= acc_d;
          remain_q <= remain_q - 4'h1;
          if (remain_q == 4'h1) begin
            state_q <= IDLE;
          end
        end
        BYTE_DONE: begin
          state_q <= IDLE;
        end
        default: begin
          state_q <= IDLE;
        end
      endcase
    end
  end

  // Result write-back; the step and the register update share one cycle.
  assign done_pulse = ((state_q == RUN) && (remain_q == 4'h1)) || (state_q == BYTE_DONE);

  // Working registers; a shift result wins over a software write to the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < shift_pkg::REG_NUM; i++) begin
        arith_operand_set_q[i] <= shift_pkg::REG_RESET;
      end
    end else begin
      if (wr_en && reg_hit && (state_q == IDLE)) begin
        arith_operand_set_q[reg_idx] <= pwdata[15:0];
      end
      if (state_q == BYTE_DONE) begin
        arith_operand_set_q[op_q.dst] <= step_out;
      end else if (done_pulse) begin
        arith_operand_set_q[op_q.dst] <= step_out;
      end
    end
  end

  // Condition flags visible in status: zero count leaves them clear.
  shift_pkg::flags_type cond_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_q <= '0;
    end else if (issue) begin
      cond_q <= '0;
    end else if (state_q == BYTE_DONE) begin
      cond_q <= step_flags;
    end else if (done_pulse) begin
      cond_q <= acc_d;
    end
  end

  assign busy = (state_q != IDLE);

  // Interrupt events: completion, overflow, precision loss, refused issue.
  assign irq_set[shift_pkg::IRQ_DONE]    = done_pulse;
  assign irq_set[shift_pkg::IRQ_OV]      = done_pulse && ((state_q == BYTE_DONE) ? step_flags.overflow
                                                                                : acc_d.overflow);
  assign irq_set[shift_pkg::IRQ_PL]      = done_pulse && ((state_q == BYTE_DONE) ? step_flags.precision_loss
                                                                                : acc_d.precision_loss);
  assign irq_set[shift_pkg::IRQ_REFUSED] = wr_en && (paddr == shift_pkg::ADDR_INSTR) && (state_q != IDLE);

  // Sticky status, write one to clear; a new event wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_q <= '0;
    end else begin
      for (int i = 0; i < shift_pkg::IRQ_W; i++) begin
        if (irq_set[i]) begin
          irq_st_q[i] <= 1'b1;
        end else if (wr_en && (paddr == shift_pkg::ADDR_IRQ_ST) && pwdata[i]) begin
          irq_st_q[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt mask register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mk_q <= '0;
    end else if (wr_en && (paddr == shift_pkg::ADDR_IRQ_MK)) begin
      irq_mk_q <= pwdata[shift_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(irq_st_q & irq_mk_q);

  // Read mux; data is registered only in the sense of coming from registers.
  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    if (psel && penable) begin
      if (reg_hit) begin
        prdata = {16'h0000, arith_operand_set_q[reg_idx]};
      end else begin
        case (paddr)
          shift_pkg::ADDR_INSTR:  prdata = {16'h0000, 9'h000, op_q.use_imm, op_q.imm, 2'b00};
          shift_pkg::ADDR_STATUS: prdata = {28'h0000000, cond_q.precision_loss, cond_q.overflow,
                                            cond_q.shifted_out, busy};
          shift_pkg::ADDR_IRQ_ST: prdata = {28'h0000000, irq_st_q};
          shift_pkg::ADDR_IRQ_MK: prdata = {28'h0000000, irq_mk_q};
          default:                pslverr = 1'b1;
        endcase
      end
    end
  end

endmodule

// ===== testbench/shift_unit_monitor.sv
// Port checker for the shift unit, bound onto its top module.
`timescale 1ns/100ps
module shift_unit_monitor (
  input wire logic        pclk,    // Core clock.
  input wire logic        presetn, // Reset, active low.
  input wire logic        psel,    // Select.
  input wire logic        penable, // Enable.
  input wire logic        pwrite,  // Write.
  input wire logic [7:0]  paddr,   // Address.
  input wire logic [31:0] pwdata,  // Write data.
  input wire logic [31:0] prdata,  // Read data.
  input wire logic        pready,  // Ready.
  input wire logic        pslverr, // Error.
  input wire logic        busy,    // Shift running.
  input wire logic        irq      // Interrupt.
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       acc;
  logic       issue;
  logic       imm_op;
  logic       bad;
  logic [3:0] cnt_q;
  logic       trk_q;
  // Decode of an accepted instruction write as it shows on the bus.
  assign acc    = psel && penable;
  assign issue  = acc && pwrite && paddr == shift_pkg::ADDR_INSTR && !busy;
  assign imm_op = pwdata[15:7] inside {shift_pkg::OPC_SHLI, shift_pkg::OPC_SHLSI, shift_pkg::OPC_SHRI,
                                       shift_pkg::OPC_SHRSI};
  assign bad    = !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c} || (paddr[7:5] == 3'b001 && paddr[1:0] == 2'b00));
  // Steps left of an immediate shift; register counts are not visible at the ports.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      trk_q <= 1'b0;
    end else if (issue) begin
      cnt_q <= pwdata[6:3];
      trk_q <= imm_op;
    end else if (busy) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  imm_start_a: assert property (issue && imm_op && pwdata[6:3] != 4'h0 |=> busy && cnt_q == $past(pwdata[6:3]))
    else $error("immediate shift did not start");
  imm_mid_a: assert property (trk_q && busy && cnt_q > 4'h1 |=> busy)
    else $error("immediate shift ended early");
  imm_last_a: assert property (trk_q && busy && cnt_q == 4'h1 |=> !busy)
    else $error("immediate shift ran long");
  zero_count_a: assert property (issue && imm_op && pwdata[6:3] == 4'h0 |=> !busy)
    else $error("zero count raised busy");
  byte_single_a: assert property (issue && pwdata[15:3] == shift_pkg::OPC_BYTE_RIGHT_SHIFT |=> busy ##1 !busy)
    else $error("byte shift not one cycle");
  busy_cause_a: assert property ($rose(busy) |-> $past(issue))
    else $error("busy without an instruction");
  status_busy_a: assert property (acc && !pwrite && paddr == shift_pkg::ADDR_STATUS |-> prdata[0] == busy)
    else $error("status busy bit wrong");
  bad_addr_a: assert property (acc && bad |-> pslverr)
    else $error("unmapped address not refused");
  upper_zero_a: assert property (acc && !pwrite && !bad && paddr[5] |-> prdata[31:16] == 16'h0000)
    else $error("working register upper half not zero");
endmodule

bind shift_unit shift_unit_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .busy(busy), .irq(irq));

// ===== testbench/sequencer_model.sv
// Behavioural instruction sequencer that masters the register bus.
`timescale 1ns/100ps
module sequencer_model (
  input  wire logic        pclk,    // Core clock.
  input  wire logic        pready,  // Slave ready.
  input  wire logic        pslverr, // Slave error.
  input  wire logic        busy,    // Shift running.
  output logic             psel,    // Select.
  output logic             penable, // Enable.
  output logic             pwrite,  // Write.
  output logic      [7:0]  paddr,   // Address.
  output logic      [31:0] pwdata   // Write data.
);
  // Idle bus at time zero.
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end
  // One transfer; afterwards address and write data show the inverse so stale values are never trusted.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] dt, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~dt;
  endtask
  // No new work until busy drops; the bench timeout bounds a hang.
  task automatic wait_done(output int cycles);
    cycles = 0;
    @(posedge pclk);
    while (busy === 1'b1) begin
      cycles++;
      @(posedge pclk);
    end
  endtask
endmodule

// ===== testbench/shift_unit_test.sv
// Self-checking bench for the shift unit driven through the sequencer model.
`timescale 1ns/100ps
module shift_unit_test;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, busy, irq, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, m;
  logic [31:0] exp_q[$], msk_q[$];
  int          n_fail = 0, n_checks = 0, cyc = 0, nc;
  logic [15:0] v, r;
  logic [3:0]  n, fl;
  logic [2:0]  d, c;
  logic [3:0]  fmask [9] = '{4'h7, 4'h3, 4'hb, 4'hb, 4'h7, 4'h7, 4'hb, 4'h7, 4'hb};

  always #20 pclk = ~pclk;
  shift_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy), .irq(irq));
  sequencer_model seq (.pclk(pclk), .pready(pready), .pslverr(pslverr), .busy(busy), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  task automatic check_val(input string what, input logic [31:0] e, input logic [31:0] got);
    n_checks++;
    if (got !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, e, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Each completed read takes the oldest expectation noted by the driver.
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      m = msk_q.pop_front();
      check_val("prdata", exp_q.pop_front() & m, prdata & m);
    end
  end
  // Cycle ceiling far above the thousand or so cycles the tests need.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk);
    exp_q.push_back(e);
    msk_q.push_back(mk);
    seq.xfer(1'b0, a, 32'h0, err);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    seq.xfer(1'b1, a, dt, err);
  endtask
  // Stepwise reference: one position per step, returns {pl, ov, sb, value}.
  function automatic logic [18:0] model(input int op, input logic [15:0] x, input logic [3:0] k);
    logic sb, ov, pl;
    sb = 1'b0;
    ov = 1'b0;
    pl = 1'b0;
    for (int i = 0; i < k; i++) begin
      if (op == 0 || op == 4) begin
        // Plain left shifts, by register or by literal, flag any one leaving the top.
        sb = x[15];
        ov = ov | x[15];
        x  = x << 1;
      end else if (op == 1 || op == 5) begin
        sb = x[14];
        ov = ov | (x[14] != x[15]);
        x  = {x[15], x[13:0], 1'b0};
      end else begin
        sb = x[0];
        pl = pl | x[0];
        ov = ov | x[0];
        x  = (op == 3 || op == 7) ? {x[15], x[15:1]} : x >> 1;
      end
    end
    return {pl, ov, sb, x};
  endfunction
  function automatic logic [15:0] instr(input int op, input logic [2:0] dd, input logic [2:0] cc, input logic [3:0] k);
    case (op)
      0: return {shift_pkg::OPC_SHL, cc, dd};
      1: return {shift_pkg::OPC_SHLS, cc, dd};
      2: return {shift_pkg::OPC_SHR, cc, dd};
      3: return {shift_pkg::OPC_SHRS, cc, dd};
      4: return {shift_pkg::OPC_SHLI, k, dd};
      5: return {shift_pkg::OPC_SHLSI, k, dd};
      6: return {shift_pkg::OPC_SHRI, k, dd};
      7: return {shift_pkg::OPC_SHRSI, k, dd};
      default: return {shift_pkg::OPC_BYTE_RIGHT_SHIFT, dd};
    endcase
  endfunction

  initial begin
    void'($urandom(59391));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(shift_pkg::ADDR_STATUS, 32'h0, 32'hffffffff);
    rd(shift_pkg::ADDR_REG0, 32'h0, 32'hffffffff);
    $display("test reset done");
    // Every opcode at count zero, fifteen and two random counts.
    for (int op = 0; op < 9; op++) begin
      for (int t = 0; t < 4; t++) begin
        d = 3'($urandom);
        c = d + 3'(1 + $urandom % 7);
        n = (t == 0) ? 4'h0 : (t == 1) ? 4'hf : 4'($urandom);
        v = 16'($urandom);
        wr(shift_pkg::ADDR_REG0 + 8'(4 * d), {16'h0, v});
        wr(shift_pkg::ADDR_REG0 + 8'(4 * c), {28'h0, n});
        wr(shift_pkg::ADDR_INSTR, {16'h0, instr(op, d, c, n)});
        seq.wait_done(nc);
        check_val("cycles", (op == 8) ? 32'h1 : 32'(n), nc);
        {fl[3:1], r} = model(op, v, (op == 8) ? 4'h8 : n);
        fl[0] = 1'b0;
        rd(shift_pkg::ADDR_REG0 + 8'(4 * d), {16'h0, r}, 32'hffffffff);
        rd(shift_pkg::ADDR_STATUS, {28'h0, fl}, {28'h0, fmask[op]});
      end
    end
    $display("test opcodes done");
    // Work offered while busy is refused and raises the refusal interrupt.
    v = 16'($urandom);
    wr(shift_pkg::ADDR_REG0, {16'h0, v});
    wr(shift_pkg::ADDR_INSTR, {16'h0, instr(6, 3'h0, 3'h0, 4'hf)});
    wr(shift_pkg::ADDR_INSTR, {16'h0, instr(8, 3'h0, 3'h0, 4'h0)});
    wr(shift_pkg::ADDR_REG0, 32'h0000ffff);
    seq.wait_done(nc);
    rd(shift_pkg::ADDR_REG0, {16'h0, v >> 15}, 32'hffffffff);
    rd(shift_pkg::ADDR_IRQ_ST, 32'h8, 32'h8);
    check_val("irq", 32'h0, irq);
    wr(shift_pkg::ADDR_IRQ_MK, 32'h8);
    @(posedge pclk);
    check_val("irq", 32'h1, irq);
    wr(shift_pkg::ADDR_IRQ_ST, 32'hf);
    @(posedge pclk);
    check_val("irq", 32'h0, irq);
    wr(8'h10, 32'h1);
    check_val("pslverr", 32'h1, err);
    $display("test refusal done");
    print_verdict();
  end
endmodule
